/* File: rtl/fss_slave_state_sequencer.sv */
// slave state sequencer with apb register file and io gating
`timescale 1ns/1ps
module fss_slave_state_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fss_pkg::IO_W-1:0] in_pins,
  output logic [fss_pkg::IO_W-1:0] out_pins,
  output logic mbx_en,
  output logic foe_only,
  output logic pd_en,
  output logic restore_defaults,
  output logic irq
);

  // bus handshake state
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // software visible registers
  logic [31:0] ctrl_q;
  logic [fss_pkg::CFG_W-1:0] cfg_q;
  logic [fss_pkg::IRQ_W-1:0] irq_stat_q;
  logic [fss_pkg::IRQ_W-1:0] irq_mask_q;
  logic [fss_pkg::IO_W-1:0] out_data_q;
  logic [fss_pkg::IO_W-1:0] in_image_q;
  logic [fss_pkg::IO_W-1:0] safe_val_q;
  logic err_q;
  // sequencer state
  fss_pkg::fss_state_t state_q;
  fss_pkg::fss_state_t state_d;
  logic req_fail;
  // output side flops
  logic [fss_pkg::IO_W-1:0] out_pins_q;
  logic mbx_en_q;
  logic foe_only_q;
  logic pd_en_q;
  logic restore_q;
  logic irq_q;

  // decoded bus events
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [7:0] off;
  logic req_wr;
  logic restore_hit;
  fss_pkg::fss_state_t req_state;

  assign off = paddr[7:0];
  assign addr_ok = (paddr[31:8] == 24'h00_0000) && (off[1:0] == 2'h0) &&
                   (off <= fss_pkg::OFF_SAFE_VAL);
  assign wr_acc = psel && penable && pready_q && pwrite && addr_ok;
  assign rd_acc = psel && !penable && !pwrite;
  assign req_wr = wr_acc && (off == fss_pkg::OFF_CTRL);
  assign req_state = fss_pkg::fss_state_t'(pwdata[3:0]);
  // only the magic word, or the old one with the legacy bit set, fires; anything else is ignored
  assign restore_hit = wr_acc && (off == fss_pkg::OFF_RESTORE) &&
    ((pwdata == fss_pkg::RESTORE_MAGIC) ||
     (ctrl_q[fss_pkg::CTRL_LEGACY_BIT] && pwdata == fss_pkg::RESTORE_MAGIC_OLD));

  // zero wait state slave: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
    end
  end

  // read mux and error answer, latched at the end of setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !addr_ok;
      prdata_q <= 32'h0000_0000;
      if (rd_acc && addr_ok) begin
        case (off)
          fss_pkg::OFF_CTRL: prdata_q <= ctrl_q;
          fss_pkg::OFF_STATUS: prdata_q <= {27'h0, err_q, state_q};
          fss_pkg::OFF_CFG: prdata_q <= {27'h0, cfg_q};
          fss_pkg::OFF_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
          fss_pkg::OFF_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
          fss_pkg::OFF_OUT_DATA: prdata_q <= {24'h0, out_data_q};
          fss_pkg::OFF_IN_IMAGE: prdata_q <= {24'h0, in_image_q};
          fss_pkg::OFF_SAFE_VAL: prdata_q <= {24'h0, safe_val_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control, configuration, output data and safe value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= fss_pkg::CTRL_RESET;
      cfg_q <= '0;
      out_data_q <= '0;
      safe_val_q <= '0;
      irq_mask_q <= '0;
    end else if (wr_acc) begin
      case (off)
        fss_pkg::OFF_CTRL: ctrl_q <= {22'h0, pwdata[fss_pkg::CTRL_LEGACY_BIT],
                                      pwdata[fss_pkg::CTRL_WD_BIT], 4'h0, pwdata[3:0]};
        fss_pkg::OFF_CFG: cfg_q <= pwdata[fss_pkg::CFG_W-1:0];
        fss_pkg::OFF_OUT_DATA: out_data_q <= pwdata[fss_pkg::IO_W-1:0];
        fss_pkg::OFF_SAFE_VAL: safe_val_q <= pwdata[fss_pkg::IO_W-1:0];
        fss_pkg::OFF_IRQ_MASK: irq_mask_q <= pwdata[fss_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // transition check: picks the next state or flags a refusal
  always_comb begin
    state_d = state_q;
    req_fail = 1'b0;
    if (req_wr && req_state != state_q) begin
      req_fail = 1'b1;
      case (state_q)
        fss_pkg::ST_INIT: begin
          if (req_state == fss_pkg::ST_PREP &&
              cfg_q[fss_pkg::CFG_MBX0] && cfg_q[fss_pkg::CFG_MBX1]) begin
            state_d = fss_pkg::ST_PREP;
            req_fail = 1'b0;
          end else if (req_state == fss_pkg::ST_BOOT) begin
            state_d = fss_pkg::ST_BOOT;
            req_fail = 1'b0;
          end
        end
        fss_pkg::ST_PREP: begin
          if (req_state == fss_pkg::ST_GUARD && cfg_q[fss_pkg::CFG_PD] &&
              (!cfg_q[fss_pkg::CFG_DC_USED] || cfg_q[fss_pkg::CFG_DC_OK])) begin
            state_d = fss_pkg::ST_GUARD;
            req_fail = 1'b0;
          end else if (req_state == fss_pkg::ST_INIT) begin
            state_d = fss_pkg::ST_INIT;
            req_fail = 1'b0;
          end
        end
        fss_pkg::ST_GUARD: begin
          if (req_state == fss_pkg::ST_RUN || req_state == fss_pkg::ST_PREP ||
              req_state == fss_pkg::ST_INIT) begin
            state_d = req_state;
            req_fail = 1'b0;
          end
        end
        fss_pkg::ST_RUN: begin
          if (req_state == fss_pkg::ST_GUARD || req_state == fss_pkg::ST_PREP ||
              req_state == fss_pkg::ST_INIT) begin
            state_d = req_state;
            req_fail = 1'b0;
          end
        end
        fss_pkg::ST_BOOT: begin
          if (req_state == fss_pkg::ST_INIT) begin
            state_d = fss_pkg::ST_INIT;
            req_fail = 1'b0;
          end
        end
        default: state_d = fss_pkg::ST_INIT;
      endcase
    end
  end

  // sequencer state register, power-on state after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fss_pkg::ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // error flag: set on refusal, cleared by the next accepted request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (req_wr) begin
      err_q <= req_fail;
    end
  end

  // input image: loaded on entry to guarded run, refreshed while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_image_q <= '0;
    end else if (state_d == fss_pkg::ST_GUARD || state_d == fss_pkg::ST_RUN) begin
      in_image_q <= in_pins;
    end
  end

  // physical outputs: safe value unless full run, or guarded run with watchdog disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pins_q <= '0;
    end else if (state_q == fss_pkg::ST_RUN) begin
      out_pins_q <= out_data_q;
    end else if (state_q == fss_pkg::ST_GUARD && !ctrl_q[fss_pkg::CTRL_WD_BIT]) begin
      out_pins_q <= out_data_q;
    end else begin
      out_pins_q <= safe_val_q;
    end
  end

  // traffic gates per state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbx_en_q <= 1'b0;
      foe_only_q <= 1'b0;
      pd_en_q <= 1'b0;
    end else begin
      mbx_en_q <= (state_q == fss_pkg::ST_PREP) || (state_q == fss_pkg::ST_GUARD) ||
                  (state_q == fss_pkg::ST_RUN);
      foe_only_q <= (state_q == fss_pkg::ST_BOOT);
      pd_en_q <= (state_q == fss_pkg::ST_GUARD) || (state_q == fss_pkg::ST_RUN);
    end
  end

  // restore pulse towards the backup object store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= restore_hit;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_acc && off == fss_pkg::OFF_IRQ_STAT) ?
                       pwdata[fss_pkg::IRQ_W-1:0] : {fss_pkg::IRQ_W{1'b0}})) |
                    {restore_hit, req_fail, state_d != state_q};
    end
  end

  // level interrupt from unmasked status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_pins = out_pins_q;
  assign mbx_en = mbx_en_q;
  assign foe_only = foe_only_q;
  assign pd_en = pd_en_q;
  assign restore_defaults = restore_q;
  assign irq = irq_q;

  sequence s_boot_req;
    req_wr && req_state == fss_pkg::ST_BOOT;
  endsequence

  sequence s_not_from_init;
    state_q != fss_pkg::ST_INIT;
  endsequence

  a_boot_from_init: assert property (@(posedge pclk) disable iff (!presetn)
    s_boot_req and s_not_from_init |=> state_q != fss_pkg::ST_BOOT || $past(state_q) == fss_pkg::ST_BOOT)
    else $error("boot entered from a state other than power-on");
  a_reset_state: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == fss_pkg::ST_INIT |=> !mbx_en && !pd_en)
    else $error("traffic enabled in power-on state");
  a_prep_check: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_q) && state_q == fss_pkg::ST_PREP && $past(state_q) == fss_pkg::ST_INIT
    |-> $past(cfg_q[fss_pkg::CFG_MBX0] && cfg_q[fss_pkg::CFG_MBX1]))
    else $error("preparation entered without mailbox setup");
  a_guard_check: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_q) && state_q == fss_pkg::ST_GUARD && $past(state_q) == fss_pkg::ST_PREP
    |-> $past(cfg_q[fss_pkg::CFG_PD] &&
              (!cfg_q[fss_pkg::CFG_DC_USED] || cfg_q[fss_pkg::CFG_DC_OK])))
    else $error("guarded run entered without process channel setup");
  a_input_copy: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_q) && state_q == fss_pkg::ST_GUARD |-> in_image_q == $past(in_pins))
    else $error("inputs not copied on guarded run entry");
  a_safe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == fss_pkg::ST_GUARD && ctrl_q[fss_pkg::CTRL_WD_BIT] ##1
    ctrl_q[fss_pkg::CTRL_WD_BIT] && $stable(safe_val_q) |-> out_pins == $past(safe_val_q))
    else $error("outputs not safe in guarded run");
  a_run_apply: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == fss_pkg::ST_RUN |=> out_pins == $past(out_data_q) && mbx_en && pd_en)
    else $error("full run not applying outputs");
  a_boot_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == fss_pkg::ST_BOOT |=> foe_only && !pd_en && !mbx_en)
    else $error("boot state traffic gating wrong");
  a_restore_magic: assert property (@(posedge pclk) disable iff (!presetn)
    restore_defaults |-> $past(pwdata) == fss_pkg::RESTORE_MAGIC ||
    ($past(pwdata) == fss_pkg::RESTORE_MAGIC_OLD &&
     $past(ctrl_q[fss_pkg::CTRL_LEGACY_BIT])))
    else $error("restore fired on a wrong value");
  a_fail_holds: assert property (@(posedge pclk) disable iff (!presetn)
    req_wr && req_fail |=> $stable(state_q) && err_q [*1] ##1 1'b1)
    else $error("failed request changed state or left no error");

endmodule // fss_slave_state_sequencer

/* File: rtl/fss_pkg.sv */
// constants, register map and state codes for the slave state sequencer
package fss_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_RESTORE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_OUT_DATA = 8'h18;
  localparam logic [7:0] OFF_IN_IMAGE = 8'h1C;
  localparam logic [7:0] OFF_SAFE_VAL = 8'h20;
  // control fields
  localparam int CTRL_WD_BIT = 8;
  localparam int CTRL_LEGACY_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  // configuration fields
  localparam int CFG_MBX0 = 0;
  localparam int CFG_MBX1 = 1;
  localparam int CFG_PD = 2;
  localparam int CFG_DC_USED = 3;
  localparam int CFG_DC_OK = 4;
  localparam int CFG_W = 5;
  // status fields
  localparam int STAT_ERR_BIT = 4;
  // interrupt bits
  localparam int IRQ_CHANGE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_RESTORE = 2;
  localparam int IRQ_W = 3;
  // restore magic values
  localparam logic [31:0] RESTORE_MAGIC = 32'h6461_6F6C;
  localparam logic [31:0] RESTORE_MAGIC_OLD = 32'h6C6F_6164;
  // io width
  localparam int IO_W = 8;
  // sequencer states
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_PREP = 4'h2,
    ST_BOOT = 4'h3,
    ST_GUARD = 4'h4,
    ST_RUN = 4'h8
  } fss_state_t;
endpackage : fss_pkg

/* File: sim/fss_master_model.sv */
// apb master model standing in for the fieldbus master controller
`timescale 1ns/1ps
module fss_master_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung = 1'b0; // slave never answered
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // one transfer: setup, access held until pready sampled high or 32 cycles pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    // release; stale address and data are inverted, not held
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // fss_master_model

/* File: sim/fss_slave_state_sequencer_tb.sv */
// self-checking testbench for the slave state sequencer
`timescale 1ns/1ps
module fss_slave_state_sequencer_tb;
  logic pclk = 1'b0; // bus clock
  logic presetn = 1'b0; // reset, active low
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [fss_pkg::IO_W-1:0] in_pins = 8'h00; // physical inputs
  logic [fss_pkg::IO_W-1:0] out_pins;
  logic mbx_en, foe_only, pd_en, restore_defaults, irq;
  int error_cnt = 0;
  int n_compared = 0;
  int pulses = 0; // cycles with restore pulse high
  logic [31:0] rd;
  logic er;
  always #4 pclk = ~pclk;
  // count restore pulse cycles
  always @(posedge pclk) begin
    if (restore_defaults === 1'b1) pulses <= pulses + 1;
  end
  fss_master_model u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fss_slave_state_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_pins(in_pins), .out_pins(out_pins),
    .mbx_en(mbx_en), .foe_only(foe_only), .pd_en(pd_en),
    .restore_defaults(restore_defaults), .irq(irq));
  // verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bus access with hang cut-off
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_mst.xfer(w, a, d, rd, er);
    if (u_mst.hung) begin
      error_cnt++;
      $display("BAD %0t no pready", $time);
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // request a state with watchdog left on
  task automatic req(input fss_pkg::fss_state_t s);
    wr(fss_pkg::OFF_CTRL, 32'h0000_0100 | 32'(s));
  endtask
  // let lagging outputs land
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic gates(input logic [31:0] exp);
    chk({29'h0, foe_only, pd_en, mbx_en}, exp, "gates");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h1, "reset state");
    gates(32'h0);
    rdc(fss_pkg::OFF_CTRL, fss_pkg::CTRL_RESET, "ctrl reset");
    // refused request, interrupt masked then unmasked then cleared
    wr(fss_pkg::OFF_IRQ_MASK, 32'h0);
    req(fss_pkg::ST_PREP);
    rdc(fss_pkg::OFF_STATUS, 32'h11, "no mbx cfg");
    rdc(fss_pkg::OFF_IRQ_STAT, 32'h2, "refuse irq");
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(fss_pkg::OFF_IRQ_MASK, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(fss_pkg::OFF_IRQ_STAT, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(fss_pkg::OFF_IRQ_MASK, 32'h0);
    // firmware update entry and exit
    wr(fss_pkg::OFF_CFG, 32'h3);
    req(fss_pkg::ST_BOOT);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h3, "boot");
    gates(32'h4);
    req(fss_pkg::ST_PREP);
    rdc(fss_pkg::OFF_STATUS, 32'h13, "boot to prep");
    req(fss_pkg::ST_INIT);
    rdc(fss_pkg::OFF_STATUS, 32'h1, "boot to init");
    // restore trigger values
    wr(fss_pkg::OFF_RESTORE, 32'h1234_5678);
    wr(fss_pkg::OFF_RESTORE, fss_pkg::RESTORE_MAGIC_OLD);
    settle();
    chk(32'(pulses), 32'h0, "no restore");
    wr(fss_pkg::OFF_RESTORE, fss_pkg::RESTORE_MAGIC);
    settle();
    chk(32'(pulses), 32'h1, "restore");
    wr(fss_pkg::OFF_CTRL, 32'h0000_0301);
    wr(fss_pkg::OFF_RESTORE, fss_pkg::RESTORE_MAGIC_OLD);
    settle();
    chk(32'(pulses), 32'h2, "legacy restore");
    rdc(fss_pkg::OFF_IRQ_STAT, 32'h7, "irq stat");
    wr(fss_pkg::OFF_IRQ_STAT, 32'h7);
    rdc(fss_pkg::OFF_IRQ_STAT, 32'h0, "irq w1c");
    // preparation, checks before guarded run
    wr(fss_pkg::OFF_SAFE_VAL, 32'h3C);
    wr(fss_pkg::OFF_OUT_DATA, 32'h5A);
    req(fss_pkg::ST_PREP);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h2, "prep");
    gates(32'h1);
    chk({24'h0, out_pins}, 32'h3C, "prep out");
    req(fss_pkg::ST_BOOT);
    rdc(fss_pkg::OFF_STATUS, 32'h12, "prep to boot");
    req(fss_pkg::ST_GUARD);
    rdc(fss_pkg::OFF_STATUS, 32'h12, "no pd cfg");
    wr(fss_pkg::OFF_CFG, 32'hF);
    req(fss_pkg::ST_GUARD);
    rdc(fss_pkg::OFF_STATUS, 32'h12, "time base bad");
    @(posedge pclk) in_pins <= 8'hA5;
    wr(fss_pkg::OFF_CFG, 32'h1F);
    req(fss_pkg::ST_GUARD);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h4, "guard");
    rdc(fss_pkg::OFF_IN_IMAGE, 32'hA5, "in copy");
    gates(32'h3);
    chk({24'h0, out_pins}, 32'h3C, "guard safe");
    @(posedge pclk) in_pins <= 8'h96;
    settle();
    rdc(fss_pkg::OFF_IN_IMAGE, 32'h96, "in cyclic");
    wr(fss_pkg::OFF_CTRL, 32'h0000_0004);
    settle();
    chk({24'h0, out_pins}, 32'h5A, "wd off");
    wr(fss_pkg::OFF_CTRL, 32'h0000_0104);
    settle();
    chk({24'h0, out_pins}, 32'h3C, "wd on");
    // full run
    req(fss_pkg::ST_RUN);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h8, "run");
    gates(32'h3);
    chk({24'h0, out_pins}, 32'h5A, "run out");
    wr(fss_pkg::OFF_OUT_DATA, 32'hC3);
    settle();
    chk({24'h0, out_pins}, 32'hC3, "run out new");
    // stepping back down, time base unused on the third guarded entry
    req(fss_pkg::ST_GUARD);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h4, "run to guard");
    chk({24'h0, out_pins}, 32'h3C, "back to safe");
    req(fss_pkg::ST_PREP);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h2, "guard to prep");
    gates(32'h1);
    wr(fss_pkg::OFF_CFG, 32'h7);
    req(fss_pkg::ST_GUARD);
    rdc(fss_pkg::OFF_STATUS, 32'h4, "no time base");
    req(fss_pkg::ST_INIT);
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h1, "guard to init");
    gates(32'h0);
    // unmapped address
    rdc(8'h24, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped err");
    // reset in mid-run from full run
    req(fss_pkg::ST_PREP);
    req(fss_pkg::ST_GUARD);
    req(fss_pkg::ST_RUN);
    rdc(fss_pkg::OFF_STATUS, 32'h8, "run again");
    @(posedge pclk) presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rdc(fss_pkg::OFF_STATUS, 32'h1, "second reset state");
    gates(32'h0);
    chk({24'h0, out_pins}, 32'h0, "reset out");
    rdc(fss_pkg::OFF_CTRL, fss_pkg::CTRL_RESET, "ctrl reset again");
    complete_run();
  end
endmodule // fss_slave_state_sequencer_tb
